// ### bench/adc_flags_chk.sv
`timescale 1ns/10ps
module adc_flags_chk
   import adc_flags_pkg::*;
#(
   parameter int NUM_CH        = 8,
   parameter int DATA_W        = 10,
   parameter int CONV_CYCLES_P = CONV_CYCLES
) (
   input wire logic                      clk,
   input wire logic                      rst_n,
   input wire logic [ADDR_W-1:0]         addr,
   input wire logic [DATA_BUS_W-1:0]     wdata,
   input wire logic                      wr,
   input wire logic                      rd,
   input wire logic [DATA_BUS_W-1:0]     rdata,
   input wire logic [DATA_W-1:0]         sample,
   input wire logic [$clog2(NUM_CH)-1:0] mux_sel,
   input wire logic                      busy,
   input wire logic                      analog_powerdown,
   input wire logic                      irq
);
   typedef struct packed {
      logic              mode;
      logic [3:0]        mask;
      logic [NUM_CH-1:0] en;
   } shadow_type;
   shadow_type sh_reg;
   shadow_type sh_next;
   // Bus-side copy of writable fields, so readback needs no internal probe
   always_comb begin
      sh_next = sh_reg;
      if (wr && addr == OFF_MODE) sh_next.mode = wdata[MODE_SLEEP_BIT];
      if (wr && addr == OFF_INT_MASK) sh_next.mask = wdata[3:0];
      if (wr && addr == OFF_CHAN_ENABLE) sh_next.en = sh_reg.en | wdata[NUM_CH-1:0];
      if (wr && addr == OFF_CHAN_DISABLE) sh_next.en = sh_reg.en & ~wdata[NUM_CH-1:0];
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) sh_reg <= '0;
      else sh_reg <= sh_next;
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   sequence s_rd(logic [7:0] a);
      rd && addr == a;
   endsequence
   sequence s_start;
      wr && addr == OFF_CONTROL && wdata[CTRL_START_BIT] && !busy && sh_reg.en != '0;
   endsequence
   chk_rdata_idle_zero: assert property (!rd |=> rdata == 32'h0)
      else $error("read data not zero outside a read answer");
   chk_unmapped_zero: assert property (s_rd(8'h08) |=> rdata == 32'h0)
      else $error("unmapped read returned data");
   chk_status_upper: assert property (s_rd(OFF_STATUS) |=> rdata[31:18] == 14'h0)
      else $error("status upper bits not zero");
   chk_last_fields: assert property (s_rd(OFF_LAST_RESULT) |=>
      rdata[31:19] == 13'h0 && rdata[15:10] == 6'h0)
      else $error("last result unused bits not zero");
   chk_mode_back: assert property (s_rd(OFF_MODE) |=> rdata == {31'h0, $past(sh_reg.mode)})
      else $error("mode readback wrong");
   chk_mask_back: assert property (s_rd(OFF_INT_MASK) |=> rdata == {28'h0, $past(sh_reg.mask)})
      else $error("mask readback wrong");
   chk_enable_back: assert property (s_rd(OFF_CHAN_STATUS) |=>
      rdata == {{(DATA_BUS_W-NUM_CH){1'b0}}, $past(sh_reg.en)})
      else $error("channel enable readback wrong");
   chk_irq_masked: assert property (sh_reg.mask == 4'h0 |-> !irq)
      else $error("interrupt high with all sources masked");
   chk_start_busy: assert property (s_start |-> ##[1:3] busy)
      else $error("start while idle did not begin a scan");
   chk_sleep_scan_end: assert property ($rose(analog_powerdown) |->
      $past(busy) || $past(busy, 2) || $past(busy, 3))
      else $error("power down entered without a finished scan");
endmodule
bind adc_status_flags adc_flags_chk #(
   .NUM_CH(NUM_CH), .DATA_W(DATA_W), .CONV_CYCLES_P(CONV_CYCLES_P)
) chk_inst (
   .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
   .rdata(rdata), .sample(sample), .mux_sel(mux_sel), .busy(busy),
   .analog_powerdown(analog_powerdown), .irq(irq)
);

// ### bench/tb.sv
`timescale 1ns/10ps
module tb
   import adc_flags_pkg::*;
;
   localparam logic [7:0] RES1 = OFF_RESULT0 + 8'h04;
   localparam logic [7:0] RES2 = OFF_RESULT0 + 8'h08;
   // Kept short so that multi-channel scans stay cheap to walk
   localparam int         CONV_N = 4;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [9:0]  sample = 10'h155;
   logic [31:0] rdata;
   logic [2:0]  mux_sel;
   logic        busy;
   logic        analog_powerdown;
   logic        irq;
   logic [31:0] v;
   int          err_total = 0;
   int          checks_done = 0;
   int          k_end = 4;

   always #10 clk = ~clk;

   adc_status_flags #(.NUM_CH(8), .DATA_W(10), .CONV_CYCLES_P(CONV_N)) dut (
      .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .sample(sample), .mux_sel(mux_sel), .busy(busy),
      .analog_powerdown(analog_powerdown), .irq(irq)
   );

   task automatic wrap_up;
      $display("Checks %0d, mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("FAIL at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr_now(input logic [7:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr_now(a, d);
   endtask
   task automatic rd_now(input logic [7:0] a, output logic [31:0] d);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      rd_now(a, d);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      rd_reg(a, v);
      chk(v, exp);
   endtask
   task automatic wait_idle;
      int n;
      n = 0;
      repeat (4) @(posedge clk);
      #1;
      while (busy !== 1'b0 && n < 1000) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk({31'h0, busy}, 32'h0);
   endtask
   task automatic scan;
      wr_reg(OFF_CONTROL, 32'h1);
      wait_idle();
   endtask
   // Issues the request so that it is sampled at the same edge as the end pulse
   task automatic co_op(input logic w, input logic [7:0] a, input logic [31:0] d);
      wr_reg(OFF_CONTROL, 32'h1);
      repeat (k_end - 1) @(posedge clk);
      if (w) wr_now(a, d);
      else rd_now(a, v);
      wait_idle();
   endtask
   task automatic clean;
      rchk(RES1, {22'h0, sample});
      rchk(OFF_STATUS, 32'h0);
   endtask

   task automatic t_reset;
      rchk(OFF_MODE, {31'h0, MODE_SLEEP_RESET});
      rchk(OFF_INT_MASK, {28'h0, INT_MASK_RESET});
      rchk(8'h08, 32'h0);
      chk({31'h0, irq}, 32'h0);
   endtask
   task automatic t_basic;
      wr_reg(OFF_CHAN_ENABLE, 32'h3);
      scan();
      rchk(OFF_STATUS, 32'h30003);
      rchk(OFF_RESULT0, 32'h155);
      rchk(OFF_STATUS, 32'h2);
      rchk(OFF_LAST_RESULT, 32'h10155);
      rchk(OFF_STATUS, 32'h0);
      wr_reg(OFF_CHAN_DISABLE, 32'h1);
      rchk(OFF_CHAN_STATUS, 32'h2);
   endtask
   // The unmasked end interrupt marks the end-pulse edge; later scans reuse it
   task automatic t_cal;
      int n;
      n = 0;
      chk({31'h0, irq}, 32'h0);
      rchk(OFF_INT_STATUS, 32'h7);
      wr_reg(OFF_INT_MASK, 32'h1);
      wr_reg(OFF_CONTROL, 32'h1);
      while (irq !== 1'b1 && n < 500) begin
         @(posedge clk);
         #1;
         n++;
      end
      k_end = n;
      chk({31'h0, irq}, 32'h1);
      wait_idle();
      rchk(OFF_INT_STATUS, 32'h3);
      chk({31'h0, irq}, 32'h0);
      wr_reg(OFF_INT_MASK, 32'h0);
      clean();
   endtask
   task automatic t_overrun;
      @(posedge clk);
      sample <= 10'h3C3;
      scan();
      scan();
      rchk(RES1, {22'h0, sample});
      co_op(1'b0, OFF_STATUS, 32'h0);
      chk(v, 32'h20200);
      rchk(OFF_STATUS, 32'h30202);
      rchk(OFF_STATUS, 32'h10002);
      clean();
   endtask
   task automatic t_cdr_read;
      scan();
      rchk(OFF_RESULT0, 32'h155);
      rchk(OFF_STATUS, 32'h2);
      co_op(1'b0, OFF_RESULT0, 32'h0);
      rchk(OFF_STATUS, 32'h202);
      clean();
   endtask
   task automatic t_last_read;
      scan();
      co_op(1'b0, OFF_LAST_RESULT, 32'h0);
      rd_reg(OFF_STATUS, v);
      chk(v & 32'h10000, 32'h10000);
      clean();
   endtask
   task automatic t_disable(input logic pre);
      if (pre) scan();
      @(posedge clk);
      sample <= pre ? 10'h0F1 : 10'h0F0;
      wr_reg(OFF_CONTROL, 32'h1);
      wr_reg(OFF_CHAN_ENABLE, 32'h1);
      repeat (k_end - 3) @(posedge clk);
      wr_now(OFF_CHAN_DISABLE, 32'h1);
      wait_idle();
      rchk(OFF_STATUS, pre ? 32'h10202 : 32'h2);
      rchk(OFF_LAST_RESULT, {13'h0, 3'h1, 6'h0, sample});
   endtask
   // Channel 1 is switched off mid-conversion, then read against its end pulse
   task automatic t_stray(input logic use_last, input logic [31:0] exp_stat);
      if (use_last) scan();
      wr_reg(OFF_CONTROL, 32'h1);
      wr_reg(OFF_CHAN_DISABLE, 32'h2);
      repeat (k_end - 3) @(posedge clk);
      rd_now(use_last ? OFF_LAST_RESULT : OFF_RESULT0, v);
      chk(v, use_last ? 32'h100F0 : 32'h155);
      wait_idle();
      rchk(OFF_STATUS, exp_stat);
      // The stale end flag of the off channel is read away, never trusted
      rchk(OFF_LAST_RESULT, 32'h100F0);
      wr_reg(OFF_CHAN_ENABLE, 32'h2);
   endtask
   // Three channels: a channel-2 read lands on channel 1's end pulse
   task automatic t_trio;
      wr_reg(OFF_CHAN_ENABLE, 32'h7);
      scan();
      rchk(OFF_STATUS, 32'h30007);
      rchk(OFF_RESULT0, 32'h0F0);
      wr_reg(OFF_CONTROL, 32'h1);
      repeat (k_end + CONV_N - 1) @(posedge clk);
      rd_now(RES2, v);
      chk(v, 32'h0F0);
      chk({29'h0, mux_sel}, 32'h2);
      wait_idle();
      rchk(OFF_STATUS, 32'h10606);
      rchk(OFF_LAST_RESULT, 32'h200F0);
      rchk(RES1, 32'h0F0);
      rchk(OFF_STATUS, 32'h0);
      wr_reg(OFF_CHAN_DISABLE, 32'h5);
   endtask
   task automatic t_sleep;
      wr_reg(OFF_MODE, 32'h1);
      rchk(OFF_MODE, 32'h1);
      repeat (10) @(posedge clk);
      #1;
      chk({31'h0, analog_powerdown}, 32'h0);
      scan();
      repeat (3) @(posedge clk);
      #1;
      chk({31'h0, analog_powerdown}, 32'h1);
      wr_reg(OFF_MODE, 32'h0);
      repeat (3) @(posedge clk);
      #1;
      chk({31'h0, analog_powerdown}, 32'h0);
   endtask

   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      t_reset();
      t_basic();
      t_cal();
      t_overrun();
      t_cdr_read();
      t_last_read();
      t_disable(1'b1);
      t_disable(1'b0);
      t_stray(1'b1, 32'h10000);
      t_stray(1'b0, 32'h2);
      t_trio();
      t_sleep();
      wrap_up();
   end
   // A few hundred cycles are expected; this span is 20000 cycles
   initial begin
      #400000;
      err_total++;
      wrap_up();
   end
endmodule

// ### shared/adc_flags_pkg.sv
package adc_flags_pkg;

   // Clock and conversion timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int CONV_TIME_NS  = 1000;
   localparam int CONV_CYCLES   = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Register bus
   localparam int ADDR_W = 8;
   localparam int DATA_BUS_W = 32;

   localparam logic [7:0] OFF_CONTROL     = 8'h00;
   localparam logic [7:0] OFF_MODE        = 8'h04;
   localparam logic [7:0] OFF_CHAN_ENABLE  = 8'h10;
   localparam logic [7:0] OFF_CHAN_DISABLE = 8'h14;
   localparam logic [7:0] OFF_CHAN_STATUS  = 8'h18;
   localparam logic [7:0] OFF_STATUS      = 8'h1C;
   localparam logic [7:0] OFF_LAST_RESULT = 8'h20;
   localparam logic [7:0] OFF_INT_STATUS  = 8'h24;
   localparam logic [7:0] OFF_INT_MASK    = 8'h28;
   localparam logic [7:0] OFF_RESULT0     = 8'h40;

   // Field positions
   localparam int CTRL_START_BIT  = 0;
   localparam int MODE_SLEEP_BIT  = 0;
   localparam int STAT_EOC_LSB    = 0;
   localparam int STAT_CHANNEL_OVERRUN_FLAG_LSB   = 8;
   localparam int STAT_DATA_READY_FLAG_BIT   = 16;
   localparam int STAT_GENERAL_OVERRUN_FLAG_BIT  = 17;
   localparam int LAST_CH_LSB     = 16;
   localparam int INT_EOC_BIT     = 0;
   localparam int INT_DATA_READY_FLAG_BIT    = 1;
   localparam int INT_GENERAL_OVERRUN_FLAG_BIT   = 2;
   localparam int INT_CHANNEL_OVERRUN_FLAG_BIT    = 3;
   localparam int INT_W           = 4;

   // Reset values
   localparam logic       MODE_SLEEP_RESET = 1'b0;
   localparam logic [3:0] INT_MASK_RESET   = 4'h0;

   typedef enum logic [0:0] {
      SEQ_IDLE    = 1'b0,
      SEQ_CONVERT = 1'b1
   } seq_state_type;

endpackage

// ### src/adc_status_flags.sv
// Notes on behaviour
// - Any channel result read clears the ready flag, not only last-result read.
// - Last-result read with conversion while ready set keeps ready set regardless.
// - Result read during conversion on x with x end flag set skips ready.
// - Disable write coinciding with conversion still stores data but skips ready.
// - Status read coinciding with conversion leaves general overrun untouched.
// - Status read clears general overrun; conversion while ready set sets it.
// - Result read y, x flags set, last from neither: general overrun not set.
// - Disable during conversion with x flags set: no general overrun, channel overrun set.
// - Reading channel i result or last result clears channel i end flag.
// - Status read with new conversion on i leaves its channel overrun set.
// - Result read with any conversion may set end flag of disabled converting channel.
// - Read of third channel z during conversion of y clears previous x flag.
// - Sleep selected while idle takes effect only after a later conversion ends.
//
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
module adc_status_flags
   import adc_flags_pkg::*;
#(
   parameter int NUM_CH        = 8,
   parameter int DATA_W        = 10,
   parameter int CONV_CYCLES_P = CONV_CYCLES
) (
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire logic [ADDR_W-1:0]     addr,
   input  wire logic [DATA_BUS_W-1:0] wdata,
   input  wire logic                  wr,
   input  wire logic                  rd,
   output logic      [DATA_BUS_W-1:0] rdata,
   input  wire logic [DATA_W-1:0]     sample,
   output logic      [$clog2(NUM_CH)-1:0] mux_sel,
   output logic                       busy,
   output logic                       analog_powerdown,
   output logic                       irq
);

   localparam int CH_W = $clog2(NUM_CH);

   typedef struct packed {
      logic [NUM_CH-1:0][DATA_W-1:0] result;
      logic [DATA_W-1:0]             last_data;
      logic [CH_W-1:0]               last_ch;
      logic                          last_valid;
      logic [NUM_CH-1:0]             en;
      logic [NUM_CH-1:0]             eoc_flag;
      logic [NUM_CH-1:0]             channel_overrun_flag;
      logic                          data_ready_flag;
      logic                          general_overrun_flag;
      logic                          sleep_sel;
      logic                          start;
      logic [INT_W-1:0]              int_stat;
      logic [INT_W-1:0]              int_mask;
      logic [DATA_BUS_W-1:0]         rdata;
   } state_type;

   state_type s_reg;
   state_type s_next;

   logic [1:0]        rst_sync_reg;
   logic              rst_sync_n;
   logic              eoc;
   logic [CH_W-1:0]   eoc_ch;
   logic [DATA_W-1:0] eoc_data;

   // Asynchronous assertion, synchronous release
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync_reg <= 2'b00;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end

   assign rst_sync_n = rst_sync_reg[1];

   conversion_sequencer #(
      .NUM_CH        (NUM_CH),
      .DATA_W        (DATA_W),
      .CH_W          (CH_W),
      .CONV_CYCLES_P (CONV_CYCLES_P)
   ) u_seq (
      .clk        (clk),
      .rst_sync_n (rst_sync_n),
      .start      (s_reg.start),
      .chan_en    (s_reg.en),
      .sleep_sel  (s_reg.sleep_sel),
      .sample     (sample),
      .eoc        (eoc),
      .eoc_ch     (eoc_ch),
      .eoc_data   (eoc_data),
      .mux_sel    (mux_sel),
      .busy       (busy),
      .asleep     (analog_powerdown)
   );

   // Bus decode
   logic              wr_ctrl;
   logic              wr_mode;
   logic              wr_enable;
   logic              wr_disable;
   logic              wr_mask;
   logic              rd_status;
   logic              rd_last;
   logic              rd_int;
   logic              rd_res;
   logic [CH_W-1:0]   res_idx;
   logic [ADDR_W-1:0] res_off;

   // Flag update terms
   logic              dis_any;
   logic              en_x;
   logic              eoc_x;
   logic              store;
   logic              data_ready_flag_set;
   logic              data_ready_flag_clr;
   logic              data_ready_flag_keep;
   logic              general_overrun_flag_set;
   logic              general_overrun_flag_hold;
   logic              last_other;
   logic              rogue_eoc;
   logic              spurious;
   logic [CH_W-1:0]   clr_idx;
   logic [NUM_CH-1:0] eoc_set;
   logic [NUM_CH-1:0] eoc_clr;
   logic [NUM_CH-1:0] channel_overrun_flag_set;
   logic [NUM_CH-1:0] channel_overrun_flag_clr;
   logic [INT_W-1:0]  int_ev;
   logic [DATA_BUS_W-1:0] rd_mux;

   always_comb begin
      res_off    = addr - OFF_RESULT0;
      wr_ctrl    = wr && (addr == OFF_CONTROL);
      wr_mode    = wr && (addr == OFF_MODE);
      wr_enable  = wr && (addr == OFF_CHAN_ENABLE);
      wr_disable = wr && (addr == OFF_CHAN_DISABLE);
      wr_mask    = wr && (addr == OFF_INT_MASK);
      rd_status  = rd && (addr == OFF_STATUS);
      rd_last    = rd && (addr == OFF_LAST_RESULT);
      rd_int     = rd && (addr == OFF_INT_STATUS);
      rd_res     = rd && (addr >= OFF_RESULT0) && (res_off < ADDR_W'(4 * NUM_CH))
                   && (addr[1:0] == 2'b00);
      res_idx    = res_off[CH_W+1:2];
   end

   always_comb begin
      dis_any = wr_disable && (|(wdata[NUM_CH-1:0] & s_reg.en));
      en_x    = s_reg.en[eoc_ch];
      eoc_x   = s_reg.eoc_flag[eoc_ch];
      store   = eoc && en_x;
      last_other = !s_reg.last_valid
                   || ((s_reg.last_ch != eoc_ch) && (s_reg.last_ch != res_idx));

      // Ready flag
      data_ready_flag_clr  = rd_last || rd_res;
      data_ready_flag_keep = rd_last && eoc && s_reg.data_ready_flag;
      data_ready_flag_set  = store
                  && !(rd_res && eoc_x)
                  && !dis_any;

      // General overrun: a status read in a conversion cycle freezes it
      general_overrun_flag_hold = rd_status && eoc;
      general_overrun_flag_set  = store && s_reg.data_ready_flag
                   && !(rd_res && eoc_x && last_other)
                   && !(dis_any && eoc_x);

      // Channel end flags; a disabled channel can still be flagged
      rogue_eoc = eoc && !en_x && rd_res;
      spurious  = rd_res && eoc && s_reg.last_valid
                  && (res_idx != eoc_ch) && (res_idx != s_reg.last_ch);
      clr_idx   = spurious ? s_reg.last_ch : res_idx;
      eoc_set   = '0;
      eoc_clr   = '0;
      channel_overrun_flag_set  = '0;
      channel_overrun_flag_clr  = '0;
      if (store || rogue_eoc) begin
         eoc_set[eoc_ch] = 1'b1;
      end
      if (rd_res) begin
         eoc_clr[clr_idx] = 1'b1;
      end
      if (rd_last && s_reg.last_valid) begin
         eoc_clr[s_reg.last_ch] = 1'b1;
      end
      if (store && eoc_x) begin
         channel_overrun_flag_set[eoc_ch] = 1'b1;
      end
      if (rd_status) begin
         channel_overrun_flag_clr = '1;
         if (eoc && s_reg.channel_overrun_flag[eoc_ch] && !eoc_x) begin
            channel_overrun_flag_clr[eoc_ch] = 1'b0;
         end
      end

      int_ev = '0;
      int_ev[INT_EOC_BIT]   = |eoc_set;
      int_ev[INT_DATA_READY_FLAG_BIT]  = data_ready_flag_set && !s_reg.data_ready_flag;
      int_ev[INT_GENERAL_OVERRUN_FLAG_BIT] = general_overrun_flag_set && !general_overrun_flag_hold;
      int_ev[INT_CHANNEL_OVERRUN_FLAG_BIT]  = |channel_overrun_flag_set;
   end

   // Read mux samples the state before this cycle's update
   always_comb begin
      rd_mux = '0;
      if (rd_res) begin
         rd_mux[DATA_W-1:0] = s_reg.result[res_idx];
      end else begin
         unique case (addr)
            OFF_MODE: begin
               rd_mux[MODE_SLEEP_BIT] = s_reg.sleep_sel;
            end
            OFF_CHAN_STATUS: begin
               rd_mux[NUM_CH-1:0] = s_reg.en;
            end
            OFF_STATUS: begin
               rd_mux[STAT_EOC_LSB +: NUM_CH]  = s_reg.eoc_flag;
               rd_mux[STAT_CHANNEL_OVERRUN_FLAG_LSB +: NUM_CH] = s_reg.channel_overrun_flag;
               rd_mux[STAT_DATA_READY_FLAG_BIT]           = s_reg.data_ready_flag;
               rd_mux[STAT_GENERAL_OVERRUN_FLAG_BIT]          = s_reg.general_overrun_flag;
            end
            OFF_LAST_RESULT: begin
               rd_mux[DATA_W-1:0]          = s_reg.last_data;
               rd_mux[LAST_CH_LSB +: CH_W] = s_reg.last_ch;
            end
            OFF_INT_STATUS: begin
               rd_mux[INT_W-1:0] = s_reg.int_stat;
            end
            OFF_INT_MASK: begin
               rd_mux[INT_W-1:0] = s_reg.int_mask;
            end
            default: begin
               rd_mux = '0;
            end
         endcase
      end
   end

   always_comb begin
      s_next = s_reg;
      s_next.start = wr_ctrl && wdata[CTRL_START_BIT];
      s_next.rdata = rd ? rd_mux : '0;

      if (wr_mode) begin
         s_next.sleep_sel = wdata[MODE_SLEEP_BIT];
      end
      if (wr_mask) begin
         s_next.int_mask = wdata[INT_W-1:0];
      end
      if (wr_enable) begin
         s_next.en = s_reg.en | wdata[NUM_CH-1:0];
      end
      if (wr_disable) begin
         s_next.en = s_reg.en & ~wdata[NUM_CH-1:0];
      end

      // Data is stored even when a disable lands in the same cycle
      if (store) begin
         s_next.result[eoc_ch] = eoc_data;
         s_next.last_data      = eoc_data;
         s_next.last_ch        = eoc_ch;
         s_next.last_valid     = 1'b1;
      end

      // Set wins over clear on every hardware-set flag except general overrun, which holds its value
      s_next.eoc_flag = (s_reg.eoc_flag & ~eoc_clr) | eoc_set;
      s_next.channel_overrun_flag     = (s_reg.channel_overrun_flag & ~channel_overrun_flag_clr) | channel_overrun_flag_set;

      if (data_ready_flag_keep || data_ready_flag_set) begin
         s_next.data_ready_flag = 1'b1;
      end else if (data_ready_flag_clr) begin
         s_next.data_ready_flag = 1'b0;
      end

      if (general_overrun_flag_hold) begin
         s_next.general_overrun_flag = s_reg.general_overrun_flag;
      end else if (general_overrun_flag_set) begin
         s_next.general_overrun_flag = 1'b1;
      end else if (rd_status) begin
         s_next.general_overrun_flag = 1'b0;
      end

      s_next.int_stat = (rd_int ? '0 : s_reg.int_stat) | int_ev;
   end

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         s_reg           <= '0;
         s_reg.sleep_sel <= MODE_SLEEP_RESET;
         s_reg.int_mask  <= INT_MASK_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   assign rdata = s_reg.rdata;
   assign irq   = |(s_reg.int_stat & s_reg.int_mask);

endmodule

// ### src/conversion_sequencer.sv
`timescale 1ns/10ps
module conversion_sequencer
   import adc_flags_pkg::*;
#(
   parameter int NUM_CH        = 8,
   parameter int DATA_W        = 10,
   parameter int CH_W          = 3,
   parameter int CONV_CYCLES_P = CONV_CYCLES
) (
   input  wire logic              clk,
   input  wire logic              rst_sync_n,
   input  wire logic              start,
   input  wire logic [NUM_CH-1:0] chan_en,
   input  wire logic              sleep_sel,
   input  wire logic [DATA_W-1:0] sample,
   output logic                   eoc,
   output logic [CH_W-1:0]        eoc_ch,
   output logic [DATA_W-1:0]      eoc_data,
   output logic [CH_W-1:0]        mux_sel,
   output logic                   busy,
   output logic                   asleep
);

   localparam int CNT_W = $clog2(CONV_CYCLES_P + 1);

   typedef struct packed {
      seq_state_type     state;
      logic [CH_W-1:0]   ch;
      logic [NUM_CH-1:0] pend;
      logic [CNT_W-1:0]  cnt;
      logic              eoc;
      logic [CH_W-1:0]   eoc_ch;
      logic [DATA_W-1:0] data;
      logic              asleep;
   } seq_type;

   seq_type s_reg;
   seq_type s_next;

   // Lowest set bit wins, so a scan walks channels upward
   function automatic logic [CH_W-1:0] first_set(input logic [NUM_CH-1:0] m);
      logic [CH_W-1:0] idx;
      idx = '0;
      for (int i = NUM_CH - 1; i >= 0; i--) begin
         if (m[i]) begin
            idx = CH_W'(i);
         end
      end
      return idx;
   endfunction

   always_comb begin
      s_next = s_reg;
      s_next.eoc = 1'b0;
      unique case (s_reg.state)
         SEQ_IDLE: begin
            if (start && (|chan_en)) begin
               s_next.ch = first_set(chan_en);
               s_next.pend = chan_en & ~(NUM_CH'(1) << first_set(chan_en));
               s_next.cnt = '0;
               s_next.state = SEQ_CONVERT;
               s_next.asleep = 1'b0;
            end else if (!sleep_sel) begin
               s_next.asleep = 1'b0;
            end
         end
         SEQ_CONVERT: begin
            s_next.cnt = s_reg.cnt + CNT_W'(1);
            if (s_reg.cnt == CNT_W'(CONV_CYCLES_P - 1)) begin
               s_next.eoc = 1'b1;
               s_next.eoc_ch = s_reg.ch;
               s_next.data = sample;
               s_next.cnt = '0;
               if (|s_reg.pend) begin
                  s_next.ch = first_set(s_reg.pend);
                  s_next.pend = s_reg.pend & ~(NUM_CH'(1) << first_set(s_reg.pend));
               end else begin
                  s_next.state = SEQ_IDLE;
                  // Sleep is only taken at the end of a conversion, never from idle
                  s_next.asleep = sleep_sel;
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign eoc      = s_reg.eoc;
   assign eoc_ch   = s_reg.eoc_ch;
   assign eoc_data = s_reg.data;
   assign mux_sel  = s_reg.ch;
   assign busy     = (s_reg.state == SEQ_CONVERT);
   assign asleep   = s_reg.asleep;

endmodule
